// ### common/usrc_pkg.sv
// Purpose: Shared constants for the setup request capture block
// Assumes: 16-bit register port, byte addresses as printed
// Notes: All registers here are read-only to software
package usrc_pkg;
    // Register byte offsets
    localparam logic [7:0] USRC_OFF_UFRAME = 8'h4e;
    localparam logic [7:0] USRC_OFF_ADDR = 8'h50;
    localparam logic [7:0] USRC_OFF_REQTYPE = 8'h54;
    localparam logic [7:0] USRC_OFF_VALUE = 8'h56;
    localparam logic [7:0] USRC_OFF_INDEX = 8'h58;
    localparam logic [7:0] USRC_OFF_LENGTH = 8'h5a;
    // Field widths and reset values
    localparam int USRC_UFRAME_W = 3;
    localparam int USRC_ADDR_W = 7;
    localparam logic [6:0] USRC_ADDR_RESET = 7'h00;
    localparam logic [15:0] USRC_REG_RESET = 16'h0000;
    // Number of setup packet bytes
    localparam int USRC_SETUP_BYTES = 8;
endpackage : usrc_pkg

// ### design/usrc_setup_latch.sv
// Purpose: Holds the eight setup bytes as one atomic snapshot
// Assumes: Capture strobe comes from logic on core_clk
// Notes: Byte 0 is bmRequestType, bytes in USB wire order
`timescale 1ns/1ps
module usrc_setup_latch (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Capture side
    input wire logic capture,
    input wire logic [63:0] setup_bytes,
    // Snapshot out
    output logic [63:0] held_bytes
);
    import usrc_pkg::*;
    // One flop bank per byte, all loaded by the same strobe
    genvar gi;
    generate
        for (gi = 0; gi < USRC_SETUP_BYTES; gi++) begin : g_byte
            always_ff @(posedge core_clk or negedge rst_n) begin
                if (!rst_n) begin
                    held_bytes[gi*8 +: 8] <= 8'h00;
                end else if (capture) begin
                    held_bytes[gi*8 +: 8] <= setup_bytes[gi*8 +: 8];
                end
            end
        end
    endgenerate
endmodule : usrc_setup_latch

// ### design/usrc_top.sv
// Purpose: Setup request, device address and microframe capture
// Assumes: Events come in as one-cycle strobes on core_clk
// Notes: Register reads return data one cycle after the strobe
// Notes: Writes are taken on the bus but change nothing
// Notes on behaviour
// - Show live microframe number at Hi-Speed
// - Microframe in bits 2-0, rest zero
// - Load address only after set-address completes
// - Bus reset clears device address to zero
// - bRequest goes to upper request byte
// - bmRequestType goes to lower byte, 54H
// - Software writes to setup fields ignored
// - wValue stored, low byte bits 7-0
// - wIndex stored, low byte bits 7-0
// - wLength stored, low byte bits 7-0
`timescale 1ns/1ps
module usrc_top (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // Link-side events
    input wire logic hi_speed,
    input wire logic microframe_tick,
    input wire logic sof_seen,
    input wire logic bus_reset,
    input wire logic set_address_done,
    input wire logic [usrc_pkg::USRC_ADDR_W-1:0] new_address,
    input wire logic setup_received,
    input wire logic [63:0] setup_packet,
    // Register port
    input wire logic reg_rd,
    input wire logic reg_wr,
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata,
    output logic reg_rvalid,
    // Status outputs
    output logic [usrc_pkg::USRC_ADDR_W-1:0] device_address_field
);
    import usrc_pkg::*;

    // Reset release synchroniser
    // Both flops clear together; release lands two edges late, on one edge for all
    logic rst_meta_r;
    logic rst_n;
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rst_meta_r <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n <= rst_meta_r;
        end
    end

    // Microframe counter, wraps every eight microframes
    // Tick and SOF are core_clk strobes from the link logic, so no synchroniser
    logic [USRC_UFRAME_W-1:0] microframe_count_field;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            microframe_count_field <= '0;
        end else if (!hi_speed || sof_seen) begin
            // Full-Speed holds zero; SOF realigns to microframe 0
            microframe_count_field <= '0;
        end else if (microframe_tick) begin
            microframe_count_field <= microframe_count_field + 3'h1;
        end
    end

    // Device address; bus reset wins since it resets the whole link
    // A level bus reset keeps the address at zero for as long as it stands
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            device_address_field <= USRC_ADDR_RESET;
        end else if (bus_reset) begin
            device_address_field <= USRC_ADDR_RESET;
        end else if (set_address_done) begin
            device_address_field <= new_address;
        end
    end

    // Atomic snapshot of setup bytes
    // The capture strobe is the only load, so software cannot touch it
    logic [63:0] held_bytes;
    usrc_setup_latch u_latch (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .capture(setup_received),
        .setup_bytes(setup_packet),
        .held_bytes(held_bytes)
    );

    // Field views of the snapshot
    // Pure wiring; the low-order byte of each word sits in bits 7-0
    logic [15:0] setup_request_type_reg;
    logic [15:0] setup_value_reg;
    logic [15:0] setup_index_reg;
    logic [15:0] setup_length_reg;
    assign setup_request_type_reg = {held_bytes[15:8], held_bytes[7:0]};
    assign setup_value_reg = {held_bytes[31:24], held_bytes[23:16]};
    assign setup_index_reg = {held_bytes[47:40], held_bytes[39:32]};
    assign setup_length_reg = {held_bytes[63:56], held_bytes[55:48]};

    // Read mux; writes are never decoded, so they cannot disturb state
    // Unmapped offsets read zero so every strobe still gets an answer
    logic [15:0] rdata_nxt;
    always_comb begin
        rdata_nxt = USRC_REG_RESET;
        case (reg_addr)
            USRC_OFF_UFRAME: rdata_nxt = {13'h0000, microframe_count_field};
            USRC_OFF_ADDR: rdata_nxt = {9'h000, device_address_field};
            USRC_OFF_REQTYPE: rdata_nxt = setup_request_type_reg;
            USRC_OFF_VALUE: rdata_nxt = setup_value_reg;
            USRC_OFF_INDEX: rdata_nxt = setup_index_reg;
            USRC_OFF_LENGTH: rdata_nxt = setup_length_reg;
            default: rdata_nxt = USRC_REG_RESET;
        endcase
    end

    // Registered read data
    // Data stands between reads; a capture in the read cycle shows the older packet
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= USRC_REG_RESET;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
            if (reg_rd) begin
                reg_rdata <= rdata_nxt;
            end
        end
    end

    // Assertions, all on core_clk and idle while the internal reset is low

    // Shadow copy of the last setup packet; kept apart from the latch so
    // the read checks below do not lean on the logic that they judge
    logic [63:0] chk_setup_r;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            chk_setup_r <= '0;
        end else if (setup_received) begin
            chk_setup_r <= setup_packet;
        end
    end

    // Bus reset clears the address, even against a set-address
    a_addr_bus_reset: assert property (@(posedge core_clk) disable iff (!rst_n)
        bus_reset |=> device_address_field == USRC_ADDR_RESET)
        else $error("address not cleared");
    // Completed set-address loads the address offered with it
    a_addr_load: assert property (@(posedge core_clk) disable iff (!rst_n)
        set_address_done && !bus_reset |=> device_address_field == $past(new_address))
        else $error("address not loaded");
    // Nothing else may move the address
    a_addr_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
        !set_address_done && !bus_reset |=> $stable(device_address_field))
        else $error("address changed without cause");
    // Address read shows the field with zeros above it
    a_addr_read: assert property (@(posedge core_clk) disable iff (!rst_n)
        reg_rd && reg_addr == USRC_OFF_ADDR |=> reg_rdata == {9'h000, $past(device_address_field)})
        else $error("address read mismatch");

    // Microframe advances by one per tick at Hi-Speed
    a_ufr_step: assert property (@(posedge core_clk) disable iff (!rst_n)
        hi_speed && microframe_tick && !sof_seen |=>
        microframe_count_field == $past(microframe_count_field) + 3'h1)
        else $error("microframe not advanced");
    // SOF realigns the count to zero
    a_ufr_sof: assert property (@(posedge core_clk) disable iff (!rst_n)
        sof_seen |=> microframe_count_field == 3'h0)
        else $error("microframe not realigned");
    // Full-Speed shows zero
    a_ufr_full_speed: assert property (@(posedge core_clk) disable iff (!rst_n)
        !hi_speed |=> microframe_count_field == 3'h0)
        else $error("microframe not zero at full speed");
    // Without tick or SOF the count stands still
    a_ufr_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
        hi_speed && !microframe_tick && !sof_seen |=> $stable(microframe_count_field))
        else $error("microframe changed without tick");
    // Read shows the count in bits 2-0 and zeros above
    a_ufr_read: assert property (@(posedge core_clk) disable iff (!rst_n)
        reg_rd && reg_addr == USRC_OFF_UFRAME |=>
        reg_rvalid && reg_rdata == {13'h0000, $past(microframe_count_field)})
        else $error("microframe read mismatch");

    // Each setup read returns the packet captured before the read edge
    a_req_type: assert property (@(posedge core_clk) disable iff (!rst_n)
        reg_rd && reg_addr == USRC_OFF_REQTYPE |=> reg_rdata == $past(chk_setup_r[15:0]))
        else $error("request type mismatch");
    a_value_read: assert property (@(posedge core_clk) disable iff (!rst_n)
        reg_rd && reg_addr == USRC_OFF_VALUE |=> reg_rdata == $past(chk_setup_r[31:16]))
        else $error("value mismatch");
    a_index_read: assert property (@(posedge core_clk) disable iff (!rst_n)
        reg_rd && reg_addr == USRC_OFF_INDEX |=> reg_rdata == $past(chk_setup_r[47:32]))
        else $error("index mismatch");
    a_length_read: assert property (@(posedge core_clk) disable iff (!rst_n)
        reg_rd && reg_addr == USRC_OFF_LENGTH |=> reg_rdata == $past(chk_setup_r[63:48]))
        else $error("length mismatch");
    // All eight bytes land from the same strobe
    a_setup_capture: assert property (@(posedge core_clk) disable iff (!rst_n)
        setup_received |=> held_bytes == $past(setup_packet))
        else $error("setup bytes not captured together");
    // A write without a setup strobe leaves the snapshot held
    a_setup_wr_ignored: assert property (@(posedge core_clk) disable iff (!rst_n)
        reg_wr && !setup_received |=> $stable(held_bytes))
        else $error("write changed setup");

    // Read handshake: valid exactly one cycle after each strobe
    a_rvalid_pulse: assert property (@(posedge core_clk) disable iff (!rst_n)
        reg_rd |=> reg_rvalid)
        else $error("read not answered");
    a_rvalid_idle: assert property (@(posedge core_clk) disable iff (!rst_n)
        !reg_rd |=> !reg_rvalid)
        else $error("answer without read");
    // Read data stands until the next read
    a_rdata_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
        !reg_rd |=> $stable(reg_rdata))
        else $error("read data changed without read");
endmodule : usrc_top

// ### test/usrc_host_model.sv
// Purpose: Host-side source of setup, address and bus reset events
// Assumes: Events are taken on the core_clk edge where they are high
// Notes: Idle data shows the inverted last value, never a hold
`timescale 1ns/1ps
module usrc_host_model (
    // Clock
    input wire logic core_clk,
    // Events toward the block
    output logic setup_received,
    output logic [63:0] setup_packet,
    output logic set_address_done,
    output logic [usrc_pkg::USRC_ADDR_W-1:0] new_address,
    output logic bus_reset
);
    import usrc_pkg::*;
    // Quiet bus at time zero
    initial begin
        setup_received = 1'b0;
        setup_packet = 64'h0;
        set_address_done = 1'b0;
        new_address = 7'h00;
        bus_reset = 1'b0;
    end
    // One setup transaction, all eight bytes in one strobe
    task send_setup(input logic [63:0] p);
        @(posedge core_clk);
        #1 setup_received = 1'b1;
        setup_packet = p;
        @(posedge core_clk);
        #1 setup_received = 1'b0;
        setup_packet = ~p;
    endtask : send_setup
    // Completed set-address request
    task set_addr(input logic [6:0] a);
        @(posedge core_clk);
        #1 set_address_done = 1'b1;
        new_address = a;
        @(posedge core_clk);
        #1 set_address_done = 1'b0;
        new_address = ~a;
    endtask : set_addr
    // Bus reset pulse
    task bus_rst;
        @(posedge core_clk);
        #1 bus_reset = 1'b1;
        @(posedge core_clk);
        #1 bus_reset = 1'b0;
    endtask : bus_rst
endmodule : usrc_host_model

// ### test/usrc_top_test.sv
// Purpose: Self-checking run of the setup request capture block
// Assumes: Reads answer one cycle after the strobe
// Notes: Inputs move 1 ns after core_clk rises
`timescale 1ns/1ps
module usrc_top_test;
    import usrc_pkg::*;
    // Stimulus and observed signals
    logic core_clk = 1'b0, rstn = 1'b0, hi_speed = 1'b1, microframe_tick = 1'b0, sof_seen = 1'b0;
    logic reg_rd = 1'b0, reg_wr = 1'b0, reg_rvalid, setup_received, set_address_done, bus_reset;
    logic [7:0] reg_addr = 8'h00;
    logic [15:0] reg_wdata = 16'h0000, reg_rdata;
    logic [63:0] setup_packet;
    logic [6:0] new_address, device_address_field;
    int n_mismatch = 0, compares = 0, cyc = 0;
    always #25 core_clk = ~core_clk;
    usrc_host_model host (.core_clk(core_clk), .setup_received(setup_received), .setup_packet(setup_packet),
        .set_address_done(set_address_done), .new_address(new_address), .bus_reset(bus_reset));
    usrc_top dut (.core_clk(core_clk), .rstn(rstn), .hi_speed(hi_speed), .microframe_tick(microframe_tick),
        .sof_seen(sof_seen), .bus_reset(bus_reset), .set_address_done(set_address_done),
        .new_address(new_address), .setup_received(setup_received), .setup_packet(setup_packet),
        .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .device_address_field(device_address_field));
    task chk(input string nm, input logic [15:0] e, input logic [15:0] s);
        compares++;
        if (s !== e) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    // Register read, judged one cycle after the strobe
    task rd(input logic [7:0] a, input logic [15:0] e);
        @(posedge core_clk);
        #1 reg_rd = 1'b1;
        reg_addr = a;
        @(posedge core_clk);
        #1 reg_rd = 1'b0;
        chk("reg_rvalid", 16'h0001, {15'h0, reg_rvalid});
        chk("reg_rdata", e, reg_rdata);
    endtask : rd
    // Write attempt; the block must drop it
    task wr(input logic [7:0] a);
        @(posedge core_clk);
        #1 reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = 16'ha5a5;
        @(posedge core_clk);
        #1 reg_wr = 1'b0;
    endtask : wr
    task t_setup(input logic [63:0] p);
        host.send_setup(p);
        wr(USRC_OFF_REQTYPE);
        wr(USRC_OFF_LENGTH);
        rd(USRC_OFF_REQTYPE, p[15:0]);
        rd(USRC_OFF_VALUE, p[31:16]);
        rd(USRC_OFF_INDEX, p[47:32]);
        rd(USRC_OFF_LENGTH, p[63:48]);
    endtask : t_setup
    // Reset values of every mapped register, and an unmapped hole
    task t_reset_values;
        rd(USRC_OFF_UFRAME, 16'h0000);
        rd(USRC_OFF_ADDR, 16'h0000);
        rd(USRC_OFF_REQTYPE, 16'h0000);
        rd(USRC_OFF_VALUE, 16'h0000);
        rd(USRC_OFF_INDEX, 16'h0000);
        rd(USRC_OFF_LENGTH, 16'h0000);
        rd(8'h52, 16'h0000);
    endtask : t_reset_values
    // Bus reset and set-address in one cycle: the reset wins
    task t_addr_race(input logic [6:0] a);
        host.set_addr(a);
        fork
            host.set_addr(~a);
            host.bus_rst;
        join
        chk("device_address_field", 16'h0000, {9'h0, device_address_field});
        rd(USRC_OFF_ADDR, 16'h0000);
    endtask : t_addr_race
    // Reset in mid-run clears the address and the setup snapshot
    task t_reset_mid;
        host.set_addr(7'h15);
        @(posedge core_clk);
        #1 rstn = 1'b0;
        repeat (2) @(posedge core_clk);
        #1 chk("device_address_field", 16'h0000, {9'h0, device_address_field});
        rstn = 1'b1;
        repeat (3) @(posedge core_clk);
        rd(USRC_OFF_LENGTH, 16'h0000);
        rd(USRC_OFF_ADDR, 16'h0000);
    endtask : t_reset_mid
    task t_addr(input logic [6:0] a);
        wr(USRC_OFF_ADDR);
        rd(USRC_OFF_ADDR, 16'h0000);
        host.set_addr(a);
        chk("device_address_field", {9'h0, a}, {9'h0, device_address_field});
        rd(USRC_OFF_ADDR, {9'h0, a});
        host.bus_rst;
        rd(USRC_OFF_ADDR, 16'h0000);
    endtask : t_addr
    // Microframe wraps modulo eight; low speed forces zero
    task t_uframe;
        @(posedge core_clk);
        #1 sof_seen = 1'b1;
        @(posedge core_clk);
        #1 sof_seen = 1'b0;
        microframe_tick = 1'b1;
        repeat (9) @(posedge core_clk);
        #1 microframe_tick = 1'b0;
        rd(USRC_OFF_UFRAME, 16'h0001);
        rd(USRC_OFF_UFRAME, 16'h0001);
        hi_speed = 1'b0;
        rd(USRC_OFF_UFRAME, 16'h0000);
    endtask : t_uframe
    task print_verdict;
        if (n_mismatch == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : print_verdict
    // Hang guard
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 2000) begin
            n_mismatch++;
            print_verdict;
        end
    end
    initial begin
        repeat (12) @(posedge core_clk);
        #1 rstn = 1'b1;
        repeat (3) @(posedge core_clk);
        t_reset_values;
        t_setup(64'h0123_4567_89ab_cdef);
        t_setup(64'hfedc_ba98_7654_3210);
        t_addr(7'h7f);
        t_addr_race(7'h2a);
        t_reset_mid;
        t_uframe;
        print_verdict;
    end
endmodule : usrc_top_test
